// ---- logic/scs_dev.sv ----
// synthesizer end: serial shift register, control register and output clock synthesis
//
// Notes on behaviour
// - out3 divide: bits 121..118 plus 94
// - out3 even divide: field inverts divide/2-2
// - each output driven only while enabled
// - bit 112 low stops the PLL
// - bit 122 picks crystal or clock input
// - bits 123/124 pick out2/out3 sources
// - power-up divides 5, 50, 10, 2, 2
// - register holds default word after power-up
// - controller keeps V and R in range
// - out1 is fin*V over R*divide
// - controller keeps fin/R within band
// - V or R change moves smoothly
// - post-divider or mux change may glitch
// - word is 132 bits, MSB first
// - data sampled on shift clock rise
// - strobe high copies shifted bits over
// - controller: strobe low while shifting
// - programming accepted even while powered down
// - out2 divide: bits 117..114 plus 113
`timescale 1ns/1ps
module scs_dev (
  input wire logic clk_i,
  input wire logic nrst_i,
  scs_link_if.dev lnk,
  output logic clock_out_a_o,
  output logic clock_out_a_oe_o,
  output logic clock_out_b_o,
  output logic clock_out_b_oe_o,
  output logic clock_out_c_o,
  output logic clock_out_c_oe_o,
  output logic pll_running_o,
  output logic xtal_select_o,
  output logic word_loaded_o,
  output logic [scs_pkg::WORD_W-1:0] control_word_o
);
  import scs_pkg::*;

  typedef struct packed {
    logic [2:0] p1;
    logic [2:0] p2;
    logic [2:0] p3;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] ctrl;
    logic loaded;
    logic [2:0][ACC_W-1:0] acc;
    logic [2:0] ck;
    logic [2:0] oe;
    logic pwr;
    logic xtal;
  } scs_dev_state_type;

  localparam scs_dev_state_type RESET_STATE = '{
    p1: 3'h0,
    p2: 3'h0,
    p3: 3'h0,
    shreg: '0,
    ctrl: DEFAULT_WORD,
    loaded: 1'b0,
    acc: '0,
    ck: 3'h0,
    oe: 3'h0,
    pwr: 1'b0,
    xtal: 1'b0
  };

  scs_dev_state_type r;
  scs_dev_state_type n;

  // one accumulator step: wrap flag on top, remainder below
  function automatic logic [ACC_W:0] nco_step(input logic [ACC_W-1:0] acc,
                                             input logic [ACC_W-1:0] inc,
                                             input logic [ACC_W-1:0] modv);
    logic [ACC_W:0] sum;
    logic [ACC_W:0] diff;
    sum = {1'b0, acc} + {1'b0, inc};
    // a zero modulus parks the output
    if (modv == '0) begin
      return '0;
    end
    if (sum >= {1'b0, modv}) begin
      diff = sum - {1'b0, modv};
      // a step wider than the modulus cannot be tracked, so the phase restarts
      if (diff >= {1'b0, modv}) begin
        return {1'b1, {ACC_W{1'b0}}};
      end
      return {1'b1, diff[ACC_W-1:0]};
    end
    return {1'b0, sum[ACC_W-1:0]};
  endfunction

  logic sclk_rise;
  logic strobe_s;
  logic data_s;
  logic [10:0] vdiv;
  logic [10:0] rdiv;
  logic [2:0][5:0] pdiv;
  logic [2:0] en;
  logic [2:0] from_pll;
  logic [2:0][ACC_W-1:0] inc;
  logic [2:0][ACC_W-1:0] modv;
  logic [ACC_W:0] step;
  logic pwr;

  always_comb begin
    n = r;
    sclk_rise = 1'b0;
    strobe_s = 1'b0;
    data_s = 1'b0;
    vdiv = DEF_VDIV;
    rdiv = DEF_RDIV;
    pdiv = {DEF_PDIV_BC, DEF_PDIV_BC, DEF_PDIV_A};
    en = 3'h7;
    from_pll = 3'h7;
    pwr = 1'b1;
    inc = '0;
    modv = '0;
    step = '0;

    // link pins pass two flops before use
    n.p1 = {lnk.load_strobe, lnk.serial_data, lnk.shift_clock};
    n.p2 = r.p1;
    n.p3 = r.p2;
    sclk_rise = r.p2[0] & ~r.p3[0];
    data_s = r.p2[1];
    strobe_s = r.p2[2];

    // older bits move toward the top
    // shifting never depends on power state
    if (sclk_rise) begin
      n.shreg = {r.shreg[WORD_W-2:0], data_s};
    end

    // control register holds while strobe is low
    if (strobe_s) begin
      n.ctrl = r.shreg;
      n.loaded = 1'b1;
    end

    // documented defaults until first load
    // the wide power-up word does not decode, so fixed values stand in
    if (r.loaded) begin
      vdiv = r.ctrl[VDIV_LO +: DIV_W];
      rdiv = r.ctrl[RDIV_LO +: DIV_W];
      pdiv[1] = pdiv_decode(r.ctrl[PDIV2_HI:PDIV2_LO], r.ctrl[PDIV2_X2]);
      pdiv[2] = pdiv_decode(r.ctrl[PDIV3_HI:PDIV3_LO], r.ctrl[PDIV3_X2]);
      en = {r.ctrl[EN_C_BIT], r.ctrl[EN_B_BIT], r.ctrl[EN_A_BIT]};
      from_pll = {r.ctrl[SEL3_BIT], r.ctrl[SEL2_BIT], 1'b1};
      pwr = r.ctrl[PWR_BIT];
    end

    n.pwr = pwr;
    n.xtal = r.loaded ? r.ctrl[XTAL_BIT] : 1'b1;

    for (int i = 0; i < 3; i++) begin
      inc[i] = from_pll[i] ? ACC_W'({vdiv, 1'b0}) : ACC_W'({rdiv, 1'b0});
      modv[i] = ACC_W'(rdiv * pdiv[i]);
      step = nco_step(r.acc[i], inc[i], modv[i]);
      n.oe[i] = en[i];
      if (!en[i]) begin
        n.ck[i] = 1'b0;
      end else if (pwr || !from_pll[i]) begin
        // reference-sourced outputs keep running while the pll is down
        n.acc[i] = step[ACC_W-1:0];
        // mux or divider change may cut a phase short
        n.ck[i] = r.ck[i] ^ step[ACC_W];
      end
    end
  end

  // register comes up holding default word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign clock_out_a_o = r.ck[0];
  assign clock_out_a_oe_o = r.oe[0];
  assign clock_out_b_o = r.ck[1];
  assign clock_out_b_oe_o = r.oe[1];
  assign clock_out_c_o = r.ck[2];
  assign clock_out_c_oe_o = r.oe[2];
  assign pll_running_o = r.pwr;
  assign xtal_select_o = r.xtal;
  assign word_loaded_o = r.loaded;
  assign control_word_o = r.ctrl;

endmodule

// ---- logic/scs_pkg.sv ----
// shared constants, field positions and helpers for the serial clock synth config link
package scs_pkg;
  localparam int WORD_W = 132;
  // printed power-up word is wider than the register; the low 132 bits are kept
  localparam logic [139:0] DEFAULT_RAW = 140'h31FFDFFEE3BFFFFFFFFFFFFFFFFFF555FF2;
  localparam logic [131:0] DEFAULT_WORD = DEFAULT_RAW[131:0];

  // control word field positions
  localparam int PDIV3_HI = 121;
  localparam int PDIV3_LO = 118;
  localparam int PDIV3_X2 = 94;
  localparam int PDIV2_HI = 117;
  localparam int PDIV2_LO = 114;
  localparam int PDIV2_X2 = 113;
  localparam int EN_A_BIT = 110;
  localparam int EN_B_BIT = 111;
  localparam int PWR_BIT = 112;
  localparam int XTAL_BIT = 122;
  localparam int SEL2_BIT = 123;
  localparam int SEL3_BIT = 124;
  localparam int EN_C_BIT = 129;
  localparam int DIV_W = 11;
  localparam int VDIV_LO = 11;
  localparam int RDIV_LO = 0;

  // settings in force from power-up until the first load
  localparam logic [10:0] DEF_RDIV = 11'h005;
  localparam logic [10:0] DEF_VDIV = 11'h032;
  localparam logic [5:0] DEF_PDIV_A = 6'h0A;
  localparam logic [5:0] DEF_PDIV_BC = 6'h02;

  // output synthesis accumulator width
  localparam int ACC_W = 24;

  // host timing
  localparam int CLK_PS = 20000;
  localparam int T_STROBE_PS = 10000;
  localparam int T_HALF_PS = 40000;
  localparam logic [3:0] STROBE_CYC =
    4'((T_STROBE_PS + CLK_PS - 1) / CLK_PS > 0 ? (T_STROBE_PS + CLK_PS - 1) / CLK_PS : 1);
  localparam logic [3:0] HALF_CYC = 4'(T_HALF_PS / CLK_PS > 0 ? T_HALF_PS / CLK_PS : 1);
  localparam logic [7:0] LAST_BIT = 8'(WORD_W - 1);

  // host register offsets
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_WORD4 = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOADS = 1;

  // output 2/3 post divide: (inverted 4-bit field + 2) doubled when x2 is set
  function automatic logic [5:0] pdiv_decode(input logic [3:0] f, input logic x2);
    logic [5:0] base;
    base = {2'h0, ~f} + 6'h02;
    return x2 ? 6'(base << 1) : base;
  endfunction
endpackage

// ---- logic/scs_link_if.sv ----
// three-wire serial programming link between controller and synthesizer
`timescale 1ns/1ps
interface scs_link_if;
  logic shift_clock;
  logic serial_data;
  logic load_strobe;
  modport dev (input shift_clock, input serial_data, input load_strobe);
  modport host (output shift_clock, output serial_data, output load_strobe);
endinterface

// ---- logic/scs_host.sv ----
// controller end: register port for software, serialises the control word onto the link
`timescale 1ns/1ps
module scs_host (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic busy_o,
  scs_link_if.host lnk
);
  import scs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_STROBE
  } scs_host_st_type;

  typedef struct packed {
    scs_host_st_type st;
    logic [159:0] word;
    logic [WORD_W-1:0] sh;
    logic [7:0] bits;
    logic [3:0] tmr;
    logic [7:0] loads;
    logic sclk;
    logic sdata;
    logic load;
    logic [31:0] rdata;
    logic busy;
  } scs_host_state_type;

  localparam scs_host_state_type RESET_STATE = '{
    st: ST_IDLE,
    word: '0,
    sh: '0,
    bits: 8'h00,
    tmr: 4'h0,
    loads: 8'h00,
    sclk: 1'b0,
    sdata: 1'b0,
    load: 1'b0,
    rdata: 32'h0,
    busy: 1'b0
  };

  scs_host_state_type r;
  scs_host_state_type n;
  logic [2:0] idx;
  logic is_word;

  always_comb begin
    n = r;
    idx = addr_i[4:2];
    is_word = (addr_i <= ADDR_WORD4) && (addr_i[1:0] == 2'h0);

    if (wr_i && is_word) begin
      n.word[idx * 32 +: 32] = wdata_i;
      n.word[159:WORD_W] = '0;
    end

    n.rdata = 32'h0;
    if (rd_i) begin
      if (is_word) begin
        n.rdata = r.word[idx * 32 +: 32];
      end else if (addr_i == ADDR_STAT) begin
        n.rdata[STAT_BUSY] = (r.st != ST_IDLE);
        n.rdata[STAT_LOADS +: 8] = r.loads;
      end
    end

    unique case (r.st)
      ST_IDLE: begin
        n.sclk = 1'b0;
        n.load = 1'b0;
        if (wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_START]) begin
          // reserved bits sent as software wrote them
          n.sh = r.word[WORD_W-1:0];
          n.sdata = r.word[WORD_W-1];
          n.bits = 8'h00;
          n.tmr = HALF_CYC - 4'h1;
          n.st = ST_LOW;
        end
      end
      ST_LOW: begin
        n.tmr = r.tmr - 4'h1;
        if (r.tmr == 4'h0) begin
          n.sclk = 1'b1;
          n.tmr = HALF_CYC - 4'h1;
          n.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        n.tmr = r.tmr - 4'h1;
        if (r.tmr == 4'h0) begin
          n.sclk = 1'b0;
          n.tmr = HALF_CYC - 4'h1;
          if (r.bits == LAST_BIT) begin
            // strobe only after the whole word, clock low
            n.load = 1'b1;
            n.tmr = STROBE_CYC - 4'h1;
            n.st = ST_STROBE;
          end else begin
            n.bits = r.bits + 8'h01;
            n.sh = {r.sh[WORD_W-2:0], 1'b0};
            n.sdata = r.sh[WORD_W-2];
            n.st = ST_LOW;
          end
        end
      end
      ST_STROBE: begin
        n.tmr = r.tmr - 4'h1;
        if (r.tmr == 4'h0) begin
          n.load = 1'b0;
          n.loads = r.loads + 8'h01;
          n.st = ST_IDLE;
        end
      end
    endcase
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign busy_o = r.busy;
  assign lnk.shift_clock = r.sclk;
  assign lnk.serial_data = r.sdata;
  assign lnk.load_strobe = r.load;

endmodule

// ---- tb/scs_link_chk.sv ----
// checker for the serial link and the synthesizer control register
`timescale 1ns/1ps
module scs_link_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic shift_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic [scs_pkg::WORD_W-1:0] control_word_o,
  input wire logic word_loaded_o,
  input wire logic clock_out_a_o,
  input wire logic clock_out_a_oe_o,
  input wire logic clock_out_b_o,
  input wire logic clock_out_b_oe_o,
  input wire logic clock_out_c_o,
  input wire logic clock_out_c_oe_o,
  input wire logic pll_running_o,
  input wire logic xtal_select_o
);
  import scs_pkg::*;
  logic sc_r;
  logic [WORD_W-1:0] shadow_r;
  logic [7:0] bits_r;

  // reference shift register and bit count since the last strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sc_r <= 1'b0;
      shadow_r <= '0;
      bits_r <= 8'h00;
    end else begin
      sc_r <= shift_clock;
      if (shift_clock && !sc_r) begin
        shadow_r <= {shadow_r[WORD_W-2:0], serial_data};
        bits_r <= bits_r + 8'h01;
      end else if (load_strobe) begin
        bits_r <= 8'h00;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_load_rise;
    $rose(load_strobe);
  endsequence
  sequence s_copy_done;
    ##3 (control_word_o == $past(shadow_r, 3));
  endsequence

  a_strobe_no_shift: assert property (load_strobe |-> !shift_clock)
    else $error("shift clock high during strobe");
  a_strobe_single: assert property (s_load_rise |=> !load_strobe)
    else $error("strobe longer than one cycle");
  a_bit_count: assert property (s_load_rise |-> bits_r == 8'h84)
    else $error("strobe after wrong bit count");
  a_load_copy: assert property (s_load_rise |-> s_copy_done)
    else $error("control word not copied");
  a_data_hold: assert property ($rose(shift_clock) |-> $stable(serial_data)[*2])
    else $error("data moved around shift edge");
  a_word_steady: assert property ($changed(control_word_o) |-> $past(load_strobe, 3))
    else $error("control word changed without strobe");
  a_default_word: assert property (!word_loaded_o |-> control_word_o == DEFAULT_WORD)
    else $error("power-up word wrong");
  a_ctl_bits: assert property (s_load_rise |-> ##4 ({clock_out_c_oe_o, clock_out_b_oe_o,
    clock_out_a_oe_o, pll_running_o, xtal_select_o} == {control_word_o[EN_C_BIT],
    control_word_o[EN_B_BIT], control_word_o[EN_A_BIT], control_word_o[PWR_BIT],
    control_word_o[XTAL_BIT]}))
    else $error("control outputs disagree with word");
  a_off_quiet: assert property ((clock_out_a_oe_o || !clock_out_a_o) &&
    (clock_out_b_oe_o || !clock_out_b_o) && (clock_out_c_oe_o || !clock_out_c_o))
    else $error("disabled output not low");
endmodule

// ---- tb/serial_clock_synth_config_tb.sv ----
// bench: host and synthesizer joined over the link, driven by register calls
`timescale 1ns/1ps
module serial_clock_synth_config_tb;
  import scs_pkg::*;
  logic clk_i;
  logic nrst_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic busy_o;
  logic ca, ca_oe, cb, cb_oe, cc, cc_oe, pll_run, xtal_sel, loaded;
  logic [WORD_W-1:0] cw;
  logic [WORD_W-1:0] w1;
  logic [WORD_W-1:0] w2;
  int n_errors;
  int comparisons;

  scs_link_if lnk();
  scs_host u_scs_host (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .lnk(lnk));
  scs_dev u_scs_dev (.clk_i(clk_i), .nrst_i(nrst_i), .lnk(lnk), .clock_out_a_o(ca),
    .clock_out_a_oe_o(ca_oe), .clock_out_b_o(cb), .clock_out_b_oe_o(cb_oe),
    .clock_out_c_o(cc), .clock_out_c_oe_o(cc_oe), .pll_running_o(pll_run),
    .xtal_select_o(xtal_sel), .word_loaded_o(loaded), .control_word_o(cw));
  scs_link_chk u_scs_link_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .shift_clock(lnk.shift_clock), .serial_data(lnk.serial_data),
    .load_strobe(lnk.load_strobe), .control_word_o(cw), .word_loaded_o(loaded),
    .clock_out_a_o(ca), .clock_out_a_oe_o(ca_oe), .clock_out_b_o(cb),
    .clock_out_b_oe_o(cb_oe), .clock_out_c_o(cc), .clock_out_c_oe_o(cc_oe),
    .pll_running_o(pll_run), .xtal_select_o(xtal_sel));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_w(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk_rd(rdata_o, exp);
  endtask

  // fills the word registers and starts one transfer
  task automatic load(input logic [WORD_W-1:0] w);
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), w[32 * i +: 32]);
    end
    wr(ADDR_WORD4, {28'h0000000, w[131:128]});
    wr(ADDR_CTRL, 32'h00000001);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && k < 1000) begin
      @(posedge clk_i);
      k++;
    end
    chk_rd(32'(k < 1000), 32'h1);
    repeat (5) @(negedge clk_i);
  endtask

  // period of out2 (sel 1) or out3 (sel 2) in clock cycles, rise to rise
  task automatic chk_div(input int sel, input int exp);
    int g;
    int k;
    int t;
    logic p;
    logic c;
    g = 0;
    k = 0;
    t = 0;
    p = 1'b1;
    while (t < 2 && g < 200) begin
      @(negedge clk_i);
      c = (sel == 2) ? cc : cb;
      if (c && !p) begin
        t++;
      end
      if (t == 1) begin
        k++;
      end
      p = c;
      g++;
    end
    chk_rd(32'(k), 32'(exp));
  endtask

  // fl: out3/out2/out1 enables, power, crystal, out2/out3 sources; reserved bits stay 0
  function automatic logic [WORD_W-1:0] mk(input int d3, input int d2, input logic [6:0] fl);
    logic [WORD_W-1:0] w;
    w = '0;
    w[VDIV_LO +: DIV_W] = DEF_VDIV;
    w[RDIV_LO +: DIV_W] = DEF_RDIV;
    w[PDIV3_HI:PDIV3_LO] = ~4'(d3 == 2 ? 0 : d3 / 2 - 2);
    w[PDIV3_X2] = (d3 != 2);
    w[PDIV2_HI:PDIV2_LO] = ~4'(d2 == 2 ? 0 : d2 / 2 - 2);
    w[PDIV2_X2] = (d2 != 2);
    {w[EN_C_BIT], w[EN_B_BIT], w[EN_A_BIT], w[PWR_BIT], w[XTAL_BIT]} = fl[6:2];
    {w[SEL2_BIT], w[SEL3_BIT]} = fl[1:0];
    return w;
  endfunction

  initial begin
    nrst_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h00000000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_errors = 0;
    comparisons = 0;
    w1 = mk(34, 2, 7'h42);
    w2 = mk(4, 34, 7'h7C);
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk_w(cw, DEFAULT_WORD);
    rd(ADDR_STAT, 32'h00000000);
    chk_rd(32'({cc_oe, cb_oe, ca_oe, pll_run, xtal_sel}), 32'h1F);
    rd(8'h1C, 32'h00000000);
    load(w1);
    wait_idle();
    chk_w(cw, w1);
    chk_rd(32'({cc_oe, cb_oe, ca_oe, pll_run, xtal_sel}), 32'h10);
    chk_div(2, 34);
    rd(ADDR_STAT, 32'h00000002);
    load(w2);
    wr(ADDR_CTRL, 32'h00000001);
    wr(ADDR_WORD0, 32'hFFFFFFFF);
    wait_idle();
    chk_w(cw, w2);
    chk_rd(32'({cc_oe, cb_oe, ca_oe, pll_run, xtal_sel}), 32'h1F);
    chk_div(2, 4);
    chk_div(1, 34);
    rd(ADDR_STAT, 32'h00000004);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule
